// [ddw_pkg.sv]
package ddw_pkg;
   // ============================================================
   // frame layout
   localparam int FRAME_BITS = 16;
   localparam int CODE_BITS = 12;
   localparam int POS_ZERO = 15;
   localparam int POS_CHAN = 14;
   localparam int POS_MODE_HI = 13;
   localparam int POS_MODE_LO = 12;
   localparam int POS_CODE_MSB = 11;
   localparam logic [11:0] CODE_RESET = 12'h000;
   // ============================================================
   // mode encodings
   localparam logic [1:0] MODE_LOAD_ONLY = 2'h0;
   localparam logic [1:0] MODE_LOAD_UPDATE = 2'h1;
   localparam logic [1:0] MODE_LOAD_BOTH = 2'h2;
   localparam logic [1:0] MODE_POWER_DOWN = 2'h3;
   // output termination codes
   localparam logic [1:0] TERM_DRIVEN = 2'h0;
   localparam logic [1:0] TERM_HIZ = 2'h1;
   localparam logic [1:0] TERM_2K5 = 2'h2;
   localparam logic [1:0] TERM_100K = 2'h3;
   // ============================================================
   // timing
   localparam int CLK_MHZ = 200;
   localparam int WAKE_DELAY_US = 6;
   localparam int WAKE_CYCLES = WAKE_DELAY_US * CLK_MHZ;
   localparam int HOST_DIV = 8;
   localparam int SYNC_HIGH_NS = 10;
   localparam int SYNC_HIGH_CYCLES = (SYNC_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int FCNT_W = 5;
   localparam int WCNT_W = 13;
endpackage : ddw_pkg

// [ddw_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// three-wire write link
interface ddw_link_if;
   logic frame_sync_n;
   logic sclk;
   logic sdata;
   modport host (output frame_sync_n, output sclk, output sdata);
   modport dev (input frame_sync_n, input sclk, input sdata);
endinterface : ddw_link_if
`default_nettype wire

// [ddw_dev.sv]
// Overview of operation
// - host starts frame with frame sync low
// - shift data on falling clock while sync low
// - host avoids sync fall on clock fall
// - sixteenth fall executes the frame
// - ignore clocks after sixteenth until sync high
// - host raises sync high briefly before each frame
// - early sync rise aborts, nothing changes
// - host sends zero then channel select; in a down frame the host sends word_i[15] as the lead bit instead
// - mode bits pick one of four actions
// - last twelve bits code, msb first
// - registers hold codes 0 to 4095
// - reset clears registers, outputs at zero
// - mode 11 powers both outputs down
// - first two bits select termination
// - power-down keeps register contents
// - normal frame wakes after wake delay
// - wake delay timed from sixteenth fall
// - host idles clock high, stops clock when down
// - host idles sync and data low
`timescale 1ns/1ps
`default_nettype none
module ddw_dev
   import ddw_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   ddw_link_if.dev link,
   output logic [11:0] code_a_o,
   output logic [11:0] code_b_o,
   output logic [11:0] out_a_o,
   output logic [11:0] out_b_o,
   output logic [1:0] term_o,
   output logic powered_o,
   output logic frame_done_o
);
   // ============================================================
   // synchronisers, first stage read only by second
   logic [1:0] fs_meta_r, ck_meta_r, dt_meta_r;
   logic fs_r, ck_r, dt_r, ck_d_r;
   always_ff @(posedge clk_i)
   begin
      fs_meta_r <= {fs_meta_r[0], link.frame_sync_n};
      ck_meta_r <= {ck_meta_r[0], link.sclk};
      dt_meta_r <= {dt_meta_r[0], link.sdata};
      fs_r <= fs_meta_r[1];
      ck_r <= ck_meta_r[1];
      dt_r <= dt_meta_r[1];
      ck_d_r <= ck_r;
   end
   // ============================================================
   // frame decode
   wire ck_fall = ck_d_r & ~ck_r;
   wire sync_low = ~fs_r;
   logic [15:0] shift_r;
   logic [4:0] cnt_r;
   wire [15:0] frame = {shift_r[14:0], dt_r};
   wire take_bit = sync_low & ck_fall & (cnt_r < 5'(FRAME_BITS));
   wire last_bit = take_bit & (cnt_r == 5'(FRAME_BITS - 1));
   wire chan_b = frame[POS_CHAN];
   wire [1:0] mode = frame[POS_MODE_HI:POS_MODE_LO];
   wire [1:0] tsel = frame[POS_ZERO:POS_CHAN];
   wire [11:0] code = frame[POS_CODE_MSB:0];
   wire do_down = last_bit & (mode == MODE_POWER_DOWN);
   wire do_load = last_bit & ~do_down;
   wire wr_a = do_load & ((mode == MODE_LOAD_BOTH) | ~chan_b);
   wire wr_b = do_load & ((mode == MODE_LOAD_BOTH) | chan_b);
   wire do_upd = do_load & (mode != MODE_LOAD_ONLY);
   wire [11:0] nxt_a = wr_a ? code : code_a_o;
   wire [11:0] nxt_b = wr_b ? code : code_b_o;
   // termination pick from the address bits
   function automatic logic [1:0] term_of(input logic [1:0] sel);
      case (sel)
         2'h1: term_of = TERM_2K5;
         2'h2: term_of = TERM_100K;
         default: term_of = TERM_HIZ;
      endcase
   endfunction : term_of
   // shift register and bit counter; sync high aborts quietly
   always_ff @(posedge clk_i)
   begin
      if (srst_i || !sync_low)
      begin
         cnt_r <= '0;
         shift_r <= '0;
      end
      else if (take_bit)
      begin
         cnt_r <= cnt_r + 5'h01;
         shift_r <= frame;
      end
   end
   // ============================================================
   // converter registers and the codes shown at the outputs
   // registers follow every executed load frame; the power state never touches them
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         code_a_o <= CODE_RESET;
         code_b_o <= CODE_RESET;
      end
      else
      begin
         code_a_o <= nxt_a;
         code_b_o <= nxt_b;
      end
   end
   // output codes move only on an updating frame, even while powered down
   // so a waking frame's code is ready; only powered_o and term_o wait for the wake count
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         out_a_o <= CODE_RESET;
         out_b_o <= CODE_RESET;
      end
      else if (do_upd)
      begin
         out_a_o <= nxt_a;
         out_b_o <= nxt_b;
      end
   end
   // one-cycle strobe marking an executed frame
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         frame_done_o <= 1'b0;
      else
         frame_done_o <= last_bit;
   end
   // ============================================================
   // power state
   // the wake count starts on the executing edge; link sampling adds a few cycles
   typedef enum logic [2:0] {PS_ON = 3'b001, PS_DOWN = 3'b010, PS_WAKE = 3'b100} ddw_ps_type;
   ddw_ps_type ps_r, ps_nxt;
   logic [WCNT_W-1:0] wake_r, wake_nxt;
   logic [1:0] term_nxt;
   logic powered_nxt;
   wire wake_over = (wake_r == '0);
   // next power state; a down frame always wins, even in the middle of a wake
   always_comb
   begin
      ps_nxt = ps_r;
      wake_nxt = wake_r;
      term_nxt = term_o;
      powered_nxt = powered_o;
      case (ps_r)
         PS_ON:
         begin
            if (do_down)
            begin
               ps_nxt = PS_DOWN;
               powered_nxt = 1'b0;
               term_nxt = term_of(tsel);
            end
         end
         PS_DOWN:
         begin
            if (do_down)
               term_nxt = term_of(tsel); // a later down frame retargets the termination
            else if (do_load)
            begin
               ps_nxt = PS_WAKE;
               wake_nxt = WCNT_W'(WAKE_CYCLES - 1);
            end
         end
         PS_WAKE:
         begin
            if (do_down)
            begin
               ps_nxt = PS_DOWN;
               term_nxt = term_of(tsel);
            end
            else if (wake_over)
            begin
               ps_nxt = PS_ON;
               powered_nxt = 1'b1;
               term_nxt = TERM_DRIVEN;
            end
            else
               wake_nxt = wake_r - WCNT_W'(1);
         end
         default:
         begin
            ps_nxt = PS_ON;
            powered_nxt = 1'b1;
            term_nxt = TERM_DRIVEN;
         end
      endcase
   end
   // power registers; outputs stay straight off flip-flops
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         ps_r <= PS_ON;
         wake_r <= '0;
         term_o <= TERM_DRIVEN;
         powered_o <= 1'b1;
      end
      else
      begin
         ps_r <= ps_nxt;
         wake_r <= wake_nxt;
         term_o <= term_nxt;
         powered_o <= powered_nxt;
      end
   end
endmodule : ddw_dev
`default_nettype wire

// [ddw_host.sv]
`timescale 1ns/1ps
`default_nettype none
module ddw_host
   import ddw_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic req_i,
   input wire logic [15:0] word_i,
   output logic busy_o,
   output logic done_o,
   ddw_link_if.host link
);
   // ============================================================
   // divider-made serial clock; sync falls while clock is high
   typedef enum logic [2:0] {HS_IDLE = 3'b001, HS_SHIFT = 3'b010, HS_GAP = 3'b100} ddw_hs_type;
   ddw_hs_type st_r;
   logic [15:0] sh_r;
   logic [4:0] bit_r;
   logic [2:0] div_r;
   logic [3:0] gap_r;
   wire half = (div_r == 3'(HOST_DIV / 2 - 1));
   wire full = (div_r == 3'(HOST_DIV - 1));
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         st_r <= HS_IDLE;
         link.frame_sync_n <= 1'b0; // idles low
         link.sclk <= 1'b1;
         link.sdata <= 1'b0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         sh_r <= '0;
         bit_r <= '0;
         div_r <= '0;
         gap_r <= '0;
      end
      else
      begin
         done_o <= 1'b0;
         case (st_r)
            HS_IDLE:
            begin
               link.sclk <= 1'b1;
               if (req_i)
               begin
                  st_r <= HS_GAP; // sync high first
                  link.frame_sync_n <= 1'b1;
                  busy_o <= 1'b1;
                  // lead bit is zero except in a down frame, where it picks termination
                  sh_r <= {(word_i[13:12] == MODE_POWER_DOWN) & word_i[15], word_i[14:0]};
                  gap_r <= 4'(SYNC_HIGH_CYCLES + 3);
               end
            end
            HS_GAP:
            begin
               if (gap_r == '0)
               begin
                  st_r <= HS_SHIFT;
                  link.frame_sync_n <= 1'b0; // clock high here
                  link.sdata <= sh_r[15];
                  div_r <= '0;
                  bit_r <= '0;
               end
               else
                  gap_r <= gap_r - 4'h1;
            end
            HS_SHIFT:
            begin
               div_r <= full ? 3'h0 : div_r + 3'h1;
               if (half)
                  link.sclk <= 1'b0;
               if (full)
               begin
                  link.sclk <= 1'b1;
                  sh_r <= {sh_r[14:0], 1'b0};
                  link.sdata <= sh_r[14];
                  bit_r <= bit_r + 5'h01;
                  if (bit_r == 5'(FRAME_BITS - 1))
                  begin
                     st_r <= HS_IDLE; // idle sync and data low
                     link.frame_sync_n <= 1'b0;
                     link.sdata <= 1'b0;
                     busy_o <= 1'b0;
                     done_o <= 1'b1;
                  end
               end
            end
            default: st_r <= HS_IDLE;
         endcase
      end
   end
endmodule : ddw_host
`default_nettype wire

// [ddw_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// link and converter checks
module ddw_props
   import ddw_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic frame_sync_n,
   input wire logic sclk,
   input wire logic frame_done_o,
   input wire logic [11:0] code_a_o,
   input wire logic [11:0] code_b_o,
   input wire logic [1:0] term_o,
   input wire logic powered_o
);
   logic [12:0] since_r;
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   // cycles since the last executed frame; saturates so it never wraps
   always_ff @(posedge clk_i)
   begin
      since_r <= (srst_i | frame_done_o) ? 13'h0000 : since_r + {12'h000, ~&since_r};
   end
   a_code_a_cause: assert property ($changed(code_a_o) |-> frame_done_o) else $error("code a moved");
   a_code_b_cause: assert property ($changed(code_b_o) |-> frame_done_o) else $error("code b moved");
   a_down_keeps: assert property ($fell(powered_o) |-> $stable(code_a_o) && $stable(code_b_o))
      else $error("down changed codes");
   a_down_term: assert property ($fell(powered_o) |-> term_o != TERM_DRIVEN) else $error("down not terminated");
   a_wake_delay: assert property ($rose(powered_o) |-> since_r >= WAKE_CYCLES - 2 && since_r <= WAKE_CYCLES + 2)
      else $error("wake delay wrong");
   a_done_single: assert property (frame_done_o |=> !frame_done_o [*8]) else $error("done repeated");
   a_sync_gap: assert property ($rose(frame_sync_n) |-> frame_sync_n [*5]) else $error("sync high too short");
   a_sync_fall: assert property ($fell(frame_sync_n) |-> !$fell(sclk)) else $error("sync fell with sclk");
   // main scenarios reached
   c_done: cover property (frame_done_o);
   c_down: cover property ($fell(powered_o));
   c_wake: cover property ($rose(powered_o));
endmodule : ddw_props
`default_nettype wire

// [dual_dac_serial_write_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_write_control_tb;
   import ddw_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic req = 1'b0;
   logic [15:0] word = 16'h0000;
   logic done, powered, hbusy, hdone;
   logic [11:0] ca, cb, oa, ob, ca2;
   logic [1:0] term;
   int errors = 0;
   int checks_done = 0;
   // frame word, then codes a, b and outputs a, b
   logic [63:0] rows [5] = '{64'h0123_123_000_000_000, 64'h4fff_123_fff_000_000,
      64'h1800_800_fff_800_fff, 64'h6001_001_001_001_001, 64'h5a5c_001_a5c_001_a5c};
   // ============================================================
   // two links: host to device, bench driver to a second device
   ddw_link_if lk ();
   ddw_link_if bl ();
   ddw_host ddw_host_inst (.clk_i(clk), .srst_i(srst), .req_i(req), .word_i(word), .busy_o(hbusy), .done_o(hdone),
      .link(lk));
   ddw_dev ddw_dev_inst (.clk_i(clk), .srst_i(srst), .link(lk), .code_a_o(ca), .code_b_o(cb), .out_a_o(oa),
      .out_b_o(ob), .term_o(term), .powered_o(powered), .frame_done_o(done));
   ddw_dev ddw_dev_inst2 (.clk_i(clk), .srst_i(srst), .link(bl), .code_a_o(ca2), .code_b_o(), .out_a_o(),
      .out_b_o(), .term_o(), .powered_o(), .frame_done_o());
   ddw_props ddw_props_inst (.clk_i(clk), .srst_i(srst), .frame_sync_n(lk.frame_sync_n), .sclk(lk.sclk),
      .frame_done_o(done), .code_a_o(ca), .code_b_o(cb), .term_o(term), .powered_o(powered));
   // 200 MHz
   always #2.5 clk = ~clk;
   // ============================================================
   // tasks
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
      checks_done++;
      if (s !== e)
      begin
         $display("unexpected %s expected %h seen %h", nm, e, s);
         errors++;
      end
   endtask : chk
   task automatic xfer(input logic [15:0] w);
      int n;
      n = 0;
      word <= w;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      while (done !== 1'b1 && n < 400)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 400)
      begin
         $display("unexpected frame done expected 1 seen 0");
         errors++;
      end
      chk("host done", 12'h001, {11'h000, hdone});
      repeat (12) @(posedge clk);
      chk("host busy", 12'h000, {11'h000, hbusy});
   endtask : xfer
   // hand-driven frame; sclk is high whenever sync moves
   task automatic raw(input logic [31:0] w, input int nb);
      bl.frame_sync_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < nb; i++)
      begin
         bl.sdata <= w[31 - i];
         repeat (8) @(posedge clk);
         bl.sclk <= 1'b0;
         repeat (8) @(posedge clk);
         bl.sclk <= 1'b1;
      end
      bl.frame_sync_n <= 1'b1;
      bl.sdata <= 1'b0;
      repeat (12) @(posedge clk);
   endtask : raw
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude
   // ============================================================
   // main sequence
   initial
   begin
      bl.frame_sync_n = 1'b1;
      bl.sclk = 1'b1;
      bl.sdata = 1'b0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      repeat (6) @(posedge clk);
      chk("code a reset", CODE_RESET, ca);
      chk("out a reset", CODE_RESET, oa);
      chk("powered reset", 12'h001, {11'h000, powered});
      for (int i = 0; i < 5; i++)
      begin
         xfer(rows[i][63:48]);
         chk("code a", rows[i][47:36], ca);
         chk("code b", rows[i][35:24], cb);
         chk("out a", rows[i][23:12], oa);
         chk("out b", rows[i][11:0], ob);
      end
      $display("test rows done");
      for (int t = 0; t < 4; t++)
      begin
         xfer({t[1:0], 14'h33c3});
         chk("term", {10'h000, t == 1 ? TERM_2K5 : t == 2 ? TERM_100K : TERM_HIZ}, {10'h000, term});
         chk("asleep", 12'h000, {11'h000, powered});
         chk("kept a", 12'h001, ca);
         chk("idle sclk", 12'h001, {11'h000, lk.sclk});
         chk("idle sync data", 12'h000, {10'h000, lk.frame_sync_n, lk.sdata});
      end
      xfer(16'h1456);
      chk("wake out", 12'h456, oa);
      chk("still down", 12'h000, {11'h000, powered});
      repeat (1250) @(posedge clk);
      chk("awake", 12'h001, {11'h000, powered});
      chk("driven again", {10'h000, TERM_DRIVEN}, {10'h000, term});
      $display("test power down done");
      raw({16'h1abc, 16'h1fff}, 32);
      chk("extra clocks", 12'habc, ca2);
      raw({16'h1555, 16'h0000}, 15);
      chk("abort", 12'habc, ca2);
      $display("test link faults done");
      // reset again in mid-run; both devices must return to their power-up state
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      repeat (6) @(posedge clk);
      chk("again code a", CODE_RESET, ca);
      chk("again out b", CODE_RESET, ob);
      chk("again term", {10'h000, TERM_DRIVEN}, {10'h000, term});
      chk("again second code a", CODE_RESET, ca2);
      $display("test reset done");
      conclude();
   end
   // hang guard, far beyond the expected run of about 3600 cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      conclude();
   end
endmodule : dual_dac_serial_write_control_tb
`default_nettype wire
